// [core/pcmsp_pkg.sv]
// constants and types of the pcm serial voice port
//------------------------------------------------------------
// Contract
// - fs high over two falls means long
// - long mode drives while fs high or shifting
// - long mode releases at the later of fs fall and mid-lsb
// - previous pulse form picks next frame mode
// - output released at power-down, held off two frames after power-up
// - fs high at one fall means short
// - short mode starts on next rising edge
// - short word is 13 bits (16 in sign extension), released mid-lsb
// - short receive starts one fall after sync
// - rx clock static low selects sign extension
// - rx clock static high selects gain adjust
// - 16-bit modes clock receive from the transmit bit clock
// - prescaler measures master clock per frame
// - both syncs low a frame means standby
// - power input low powers down
// - send on rising, sample on falling edges
// - gain code adds 3 dB per step
// - attenuation defaults to zero
// - long-sync words align to frame sync rising edge; short-sync words to the next bit clock rise
//------------------------------------------------------------
package pcmsp_pkg;
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam int FRAME_US = 125;
    localparam int FRAME_CYC = FRAME_US * (SYS_CLK_HZ / HZ_PER_MHZ);
    localparam int STATIC_US = 10;
    localparam int STATIC_CYC = STATIC_US * (SYS_CLK_HZ / HZ_PER_MHZ);
    localparam int CNT_W = 12;
    localparam int SAMPLE_W = 13;
    localparam int SH_W = 16;
    localparam int WORD_STD = 13;
    localparam int WORD_EXT = 16;
    localparam int BCNT_W = 5;
    localparam int ATT_W = 3;
    localparam int ATT_DB_W = 5;
    localparam int ATT_STEP_DB = 3;
    localparam int HI_LONG = 2;
    localparam int HOLD_FRAMES = 2;
    localparam int TICKS_PER_FRAME = 32;
    localparam int MCNT_W = 11;
    localparam int FIFO_DEPTH = 16;
    localparam int PIN_N = 7;
    localparam int PIN_TBC = 0;
    localparam int PIN_RBC = 1;
    localparam int PIN_TFS = 2;
    localparam int PIN_RFS = 3;
    localparam int PIN_RSI = 4;
    localparam int PIN_MCK = 5;
    localparam int PIN_PUI = 6;
    typedef enum logic [1:0] {MODE_STD, MODE_SIGN_EXT, MODE_GAIN_ADJ} pcmsp_mode_e;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_SHIFT} pcmsp_seq_e;
endpackage : pcmsp_pkg

// [core/pcmsp_top.sv]
// pcm serial voice port: sample fifo and top level
//------------------------------------------------------------
// sample fifo
//------------------------------------------------------------
module pcmsp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, low
    input wire logic in_valid, // write request
    output logic in_ready, // room left
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // read request
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic in_ready_next, out_valid_next, push, pop;

    always_comb begin
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        in_ready_next = cnt_next != (AW+1)'(DEPTH);
        out_valid_next = cnt_next != '0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            in_ready <= in_ready_next;
            out_valid <= out_valid_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign out_data = mem[rp_reg];
endmodule : pcmsp_fifo

//------------------------------------------------------------
// top level
//------------------------------------------------------------
module pcmsp_top #(
    parameter int FIFO_DEPTH = pcmsp_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk, // 25 MHz
    input wire logic nrst, // async reset, low
    input wire logic tx_bit_clock, // transmit bit clock pin
    input wire logic rx_bit_clock_or_mode_select, // rx clock or static mode
    input wire logic tx_frame_sync, // transmit frame sync pin
    input wire logic rx_frame_sync, // receive frame sync pin
    input wire logic rx_serial_in, // receive data pin
    input wire logic master_clock, // master clock pin
    input wire logic power_up_input, // high keeps powered
    input wire logic [pcmsp_pkg::SAMPLE_W-1:0] tx_sample_data, // sample to send
    input wire logic tx_sample_valid, // sample offered
    output logic tx_sample_ready, // fifo has room
    output logic tx_serial_out, // transmit data pin
    output logic tx_serial_oe_n, // low while driving
    output logic [pcmsp_pkg::SAMPLE_W-1:0] rx_sample_data, // received sample
    output logic rx_sample_valid, // one-cycle pulse
    output logic [pcmsp_pkg::ATT_W-1:0] rx_atten_code, // attenuation code
    output logic [pcmsp_pkg::ATT_DB_W-1:0] rx_atten_db, // attenuation in dB
    output logic long_frame_mode, // long sync in use
    output pcmsp_pkg::pcmsp_mode_e port_mode, // word mode
    output logic standby, // syncs absent
    output logic powered_down, // power input low
    output logic [pcmsp_pkg::MCNT_W-1:0] mclk_per_frame, // measured divider
    output logic tick_256k, // internal bit tick
    output logic tick_8k // internal frame tick
);
    import pcmsp_pkg::*;

    //--------------------------------------------------------
    // pin synchronisers, filtered on second and third stage
    //--------------------------------------------------------
    logic [PIN_N-1:0] pins, s1_reg, s2_reg, s3_reg, flt_reg, flt_next, prv_reg;
    logic [PIN_N-1:0] rise, fall;
    logic tbc_r, tbc_f, tfs, tfs_r, tfs_f, rfs, rbc_f, rsi, mck_r;

    assign pins = {power_up_input, master_clock, rx_serial_in, rx_frame_sync,
                   tx_frame_sync, rx_bit_clock_or_mode_select, tx_bit_clock};

    always_comb begin
        flt_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & flt_reg);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            flt_reg <= '0;
            prv_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
            prv_reg <= flt_reg;
        end
    end

    assign rise = flt_reg & ~prv_reg;
    assign fall = ~flt_reg & prv_reg;
    assign tbc_r = rise[PIN_TBC];
    assign tbc_f = fall[PIN_TBC];
    assign tfs = flt_reg[PIN_TFS];
    assign tfs_r = rise[PIN_TFS];
    assign tfs_f = fall[PIN_TFS];
    assign rfs = flt_reg[PIN_RFS];
    assign rbc_f = fall[PIN_RBC];
    assign rsi = flt_reg[PIN_RSI];
    assign mck_r = rise[PIN_MCK];

    //--------------------------------------------------------
    // mode select, power, standby and prescaler
    //--------------------------------------------------------
    pcmsp_mode_e mode_next;
    logic [CNT_W-1:0] stat_reg, stat_next, idle_reg, idle_next;
    logic [1:0] hold_reg, hold_next;
    logic down_next, stby_next, asleep, allow;
    logic [MCNT_W-1:0] mcnt_reg, mcnt_next, per_next;
    logic [MCNT_W:0] acc_reg, acc_next, acc_sum;
    logic t256_next, t8_next;

    always_comb begin
        stat_next = stat_reg;
        mode_next = MODE_STD;
        if (rise[PIN_RBC] | fall[PIN_RBC]) begin
            stat_next = '0;
        end else if (stat_reg != CNT_W'(STATIC_CYC)) begin
            stat_next = stat_reg + 1'b1;
        end
        if (stat_next == CNT_W'(STATIC_CYC)) begin
            mode_next = flt_reg[PIN_RBC] ? MODE_GAIN_ADJ : MODE_SIGN_EXT;
        end
        idle_next = idle_reg;
        if (tfs | rfs) begin
            idle_next = '0;
        end else if (idle_reg != CNT_W'(FRAME_CYC)) begin
            idle_next = idle_reg + 1'b1;
        end
        stby_next = idle_next == CNT_W'(FRAME_CYC);
        down_next = ~flt_reg[PIN_PUI];
        asleep = down_next | stby_next;
        hold_next = hold_reg;
        if (asleep) begin
            hold_next = '0;
        end else if (tfs_r && hold_reg <= 2'(HOLD_FRAMES)) begin
            hold_next = hold_reg + 1'b1;
        end
        allow = hold_next > 2'(HOLD_FRAMES);
        mcnt_next = mcnt_reg;
        per_next = mclk_per_frame;
        acc_next = acc_reg;
        acc_sum = acc_reg + (MCNT_W+1)'(TICKS_PER_FRAME);
        t256_next = 1'b0;
        t8_next = tfs_r;
        if (tfs_r) begin
            per_next = mcnt_reg;
            mcnt_next = MCNT_W'(mck_r);
            acc_next = '0;
            // the master edge that opens the frame still makes a tick
            t256_next = mck_r && mclk_per_frame != '0;
        end else if (mck_r) begin
            mcnt_next = mcnt_reg + 1'b1;
            acc_next = acc_sum;
            if (mclk_per_frame != '0 && acc_sum >= {1'b0, mclk_per_frame}) begin
                acc_next = acc_sum - {1'b0, mclk_per_frame};
                t256_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= '0;
            port_mode <= MODE_STD;
            idle_reg <= '0;
            standby <= 1'b0;
            powered_down <= 1'b1;
            hold_reg <= '0;
            mcnt_reg <= '0;
            mclk_per_frame <= '0;
            acc_reg <= '0;
            tick_256k <= 1'b0;
            tick_8k <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            port_mode <= mode_next;
            idle_reg <= idle_next;
            standby <= stby_next;
            powered_down <= down_next;
            hold_reg <= hold_next;
            mcnt_reg <= mcnt_next;
            mclk_per_frame <= per_next;
            acc_reg <= acc_next;
            tick_256k <= t256_next;
            tick_8k <= t8_next;
        end
    end

    //--------------------------------------------------------
    // transmit: sync classification and shifter
    //--------------------------------------------------------
    pcmsp_seq_e tst_reg, tst_next;
    logic [SH_W-1:0] tsh_reg, tsh_next;
    logic [BCNT_W-1:0] tcnt_reg, tcnt_next, tlen;
    logic [1:0] hi_reg, hi_next;
    logic long_next, tfl_reg, tfl_next, pop, out_next, oen_next, fifo_valid;
    logic [SAMPLE_W-1:0] fifo_data, word;

    pcmsp_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .nrst(nrst),
        .in_valid(tx_sample_valid),
        .in_ready(tx_sample_ready),
        .in_data(tx_sample_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    always_comb begin
        tst_next = tst_reg;
        tsh_next = tsh_reg;
        tcnt_next = tcnt_reg;
        tfl_next = tfl_reg;
        hi_next = hi_reg;
        long_next = long_frame_mode;
        pop = 1'b0;
        tlen = (port_mode == MODE_SIGN_EXT) ? BCNT_W'(WORD_EXT) : BCNT_W'(WORD_STD);
        word = fifo_valid ? fifo_data : '0;
        if (tbc_f) begin
            if (tfs) begin
                hi_next = (hi_reg == 2'(HI_LONG)) ? hi_reg : hi_reg + 1'b1;
            end else if (hi_reg != '0) begin
                long_next = hi_reg == 2'(HI_LONG);
                hi_next = '0;
            end
        end
        case (tst_reg)
            SEQ_IDLE: begin
                if (!asleep && tfs_r && long_frame_mode) begin
                    tst_next = SEQ_SHIFT;
                    pop = fifo_valid;
                end else if (!asleep && tbc_f && tfs && hi_reg == '0 && !long_frame_mode) begin
                    tst_next = SEQ_ARMED;
                end
            end
            SEQ_ARMED: begin
                if (tbc_r) begin
                    tst_next = SEQ_SHIFT;
                    pop = fifo_valid;
                end
            end
            SEQ_SHIFT: begin
                // a sync fall inside the word does not cut it short
                if (tbc_f && tcnt_reg == tlen - 1'b1) begin
                    tst_next = SEQ_IDLE;
                end else if (tbc_f) begin
                    tfl_next = 1'b1;
                end else if (tbc_r && tfl_reg && tcnt_reg != tlen - 1'b1) begin
                    tsh_next = {tsh_reg[SH_W-2:0], 1'b0};
                    tcnt_next = tcnt_reg + 1'b1;
                end
            end
            default: tst_next = SEQ_IDLE;
        endcase
        if (asleep) begin
            tst_next = SEQ_IDLE;
        end
        if (pop | (tst_reg != SEQ_SHIFT && tst_next == SEQ_SHIFT)) begin
            tcnt_next = '0;
            tfl_next = 1'b0;
            if (tlen == BCNT_W'(WORD_EXT)) begin
                tsh_next = {{(SH_W-SAMPLE_W){word[SAMPLE_W-1]}}, word};
            end else begin
                tsh_next = {word, {(SH_W-SAMPLE_W){1'b0}}};
            end
        end
        out_next = tsh_next[SH_W-1];
        oen_next = ~(allow & ((tst_next == SEQ_SHIFT) | (long_frame_mode & tfs)));
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tst_reg <= SEQ_IDLE;
            tsh_reg <= '0;
            tcnt_reg <= '0;
            tfl_reg <= 1'b0;
            hi_reg <= '0;
            long_frame_mode <= 1'b0;
            tx_serial_out <= 1'b0;
            tx_serial_oe_n <= 1'b1;
        end else begin
            tst_reg <= tst_next;
            tsh_reg <= tsh_next;
            tcnt_reg <= tcnt_next;
            tfl_reg <= tfl_next;
            hi_reg <= hi_next;
            long_frame_mode <= long_next;
            tx_serial_out <= out_next;
            tx_serial_oe_n <= oen_next;
        end
    end

    //--------------------------------------------------------
    // receive shifter
    //--------------------------------------------------------
    pcmsp_seq_e rst_reg, rst_next;
    logic [SH_W-1:0] rsh_reg, rsh_next;
    logic [BCNT_W-1:0] rcnt_reg, rcnt_next, rlen;
    logic rpf_reg, rpf_next, rbf, rval_next;
    logic [SAMPLE_W-1:0] rdat_next;
    logic [ATT_W-1:0] att_next;
    logic [ATT_DB_W-1:0] db_next;

    always_comb begin
        rst_next = rst_reg;
        rsh_next = rsh_reg;
        rcnt_next = rcnt_reg;
        rpf_next = rpf_reg;
        rval_next = 1'b0;
        rdat_next = rx_sample_data;
        att_next = rx_atten_code;
        db_next = rx_atten_db;
        rbf = (port_mode == MODE_STD) ? rbc_f : tbc_f;
        rlen = (port_mode == MODE_STD) ? BCNT_W'(WORD_STD) : BCNT_W'(WORD_EXT);
        if (rbf) begin
            rpf_next = rfs;
            case (rst_reg)
                SEQ_IDLE: begin
                    if (!asleep && rfs && !rpf_reg) begin
                        rst_next = long_frame_mode ? SEQ_SHIFT : SEQ_ARMED;
                        rcnt_next = long_frame_mode ? BCNT_W'(1) : '0;
                        rsh_next = {rsh_reg[SH_W-2:0], rsi};
                    end
                end
                SEQ_ARMED: begin
                    rst_next = SEQ_SHIFT;
                    rcnt_next = BCNT_W'(1);
                    rsh_next = {rsh_reg[SH_W-2:0], rsi};
                end
                SEQ_SHIFT: begin
                    rsh_next = {rsh_reg[SH_W-2:0], rsi};
                    rcnt_next = rcnt_reg + 1'b1;
                end
                default: rst_next = SEQ_IDLE;
            endcase
            if (rst_reg == SEQ_SHIFT && rcnt_next == rlen) begin
                rst_next = SEQ_IDLE;
                rval_next = 1'b1;
                if (port_mode == MODE_GAIN_ADJ) begin
                    rdat_next = rsh_next[SH_W-1:ATT_W];
                    att_next = rsh_next[ATT_W-1:0];
                    db_next = ATT_DB_W'(rsh_next[ATT_W-1:0] * ATT_STEP_DB);
                end else begin
                    rdat_next = rsh_next[SAMPLE_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_reg <= SEQ_IDLE;
            rsh_reg <= '0;
            rcnt_reg <= '0;
            rpf_reg <= 1'b0;
            rx_sample_valid <= 1'b0;
            rx_sample_data <= '0;
            rx_atten_code <= '0;
            rx_atten_db <= '0;
        end else begin
            rst_reg <= rst_next;
            rsh_reg <= rsh_next;
            rcnt_reg <= rcnt_next;
            rpf_reg <= rpf_next;
            rx_sample_valid <= rval_next;
            rx_sample_data <= rdat_next;
            rx_atten_code <= att_next;
            rx_atten_db <= db_next;
        end
    end

    //--------------------------------------------------------
    // assertions
    //--------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_short_go;
        tst_reg == SEQ_ARMED && tbc_r && !asleep;
    endsequence
    sequence s_rx_last;
        rst_reg == SEQ_SHIFT && rbf && rcnt_reg == rlen - 1'b1;
    endsequence

    a_long_class: assert property (tbc_f && !tfs && hi_reg == 2'(HI_LONG) |=> long_frame_mode)
        else $error("long sync not recognised");
    a_short_class: assert property (tbc_f && !tfs && hi_reg == 2'h1 |=> !long_frame_mode)
        else $error("short sync not recognised");
    a_short_start: assert property (s_short_go |=> tst_reg == SEQ_SHIFT && tcnt_reg == '0)
        else $error("short word did not start");
    a_lsb_release: assert property (tst_reg == SEQ_SHIFT && tbc_f && tcnt_reg == tlen - 1'b1
        |=> tst_reg == SEQ_IDLE)
        else $error("word not ended mid lsb");
    a_fs_release: assert property (tst_reg == SEQ_SHIFT && long_frame_mode && tbc_f && !tfs
        && tcnt_reg == tlen - 1'b1 |=> tx_serial_oe_n)
        else $error("output driven after long word and sync");
    a_long_drive: assert property (tst_reg == SEQ_SHIFT && long_frame_mode && tfs_f && !tbc_f
        && !asleep && hold_reg == 2'(HOLD_FRAMES + 1) |=> !tx_serial_oe_n)
        else $error("long word released at sync fall");
    a_wake_hold: assert property (hold_reg == '0 |=> tx_serial_oe_n [*2])
        else $error("output driven too soon after wake");
    a_down_tri: assert property (powered_down |=> tx_serial_oe_n)
        else $error("output driven while powered down");
    a_standby_in: assert property (idle_reg == CNT_W'(FRAME_CYC - 1) && !tfs && !rfs
        |=> standby)
        else $error("standby not entered");
    a_rx_word: assert property (s_rx_last |=> rx_sample_valid ##1 !rx_sample_valid)
        else $error("received word not delivered");
    a_atten_db: assert property (rx_sample_valid |-> rx_atten_db ==
        ATT_DB_W'(rx_atten_code * ATT_STEP_DB))
        else $error("attenuation not linear");
    a_frame_tick: assert property (tfs_r |=> tick_8k)
        else $error("frame tick missing");
endmodule : pcmsp_top

// [tb/pcmsp_host_model.sv]
// pcm highway host model: bit clocks, syncs, master clock and serial data
module pcmsp_host_model (
    input wire logic long_sel, // 1 = long frame sync
    input wire logic fs_en, // syncs enabled
    input wire logic [1:0] rx_mode, // 0 clocked, 1 static low, 2 static high
    input wire logic [15:0] rx_word, // word sent to the device
    input wire logic tx_serial_out, // device data
    input wire logic tx_serial_oe_n, // device drive enable
    output logic tx_bit_clock, // transmit bit clock
    output logic rx_bit_clock_or_mode_select, // rx clock or static level
    output logic tx_frame_sync, // transmit sync
    output logic rx_frame_sync, // receive sync
    output logic rx_serial_in, // data to the device
    output logic master_clock, // master clock
    output int frames, // frame periods so far, counted with or without syncs
    output logic [15:0] got_word, // word captured in the last frame
    output int got_n // bits captured in the last frame
);
    timeunit 1ns;
    timeprecision 1ps;
    // 256 kHz gives exactly 32 bits per 125 us frame
    localparam realtime HALF = 1953.125ns;
    int bcnt = 0;
    int idx;
    int nb;
    int ncap = 0;
    logic [15:0] cap = '0;
    initial begin
        tx_bit_clock = 1'b0;
        forever #(HALF) tx_bit_clock = ~tx_bit_clock;
    end
    assign master_clock = tx_bit_clock;
    assign tx_frame_sync = fs_en && (bcnt < (long_sel ? 8 : 1));
    assign rx_frame_sync = tx_frame_sync;
    assign rx_bit_clock_or_mode_select = (rx_mode == 2'd0) ? tx_bit_clock : (rx_mode == 2'd2);
    assign nb = (rx_mode == 2'd0) ? 13 : 16;
    always @(posedge tx_bit_clock) begin
        bcnt = (bcnt + 1) % 32;
        idx = long_sel ? bcnt : bcnt - 1;
        // outside the word the line toggles so stale bits cannot pass
        if (idx >= 0 && idx < nb) begin
            rx_serial_in = rx_word[nb - 1 - idx];
        end else begin
            rx_serial_in = bcnt[0];
        end
    end
    // a frame closes at the first fall after the sync rise
    always @(negedge tx_bit_clock) begin
        if (bcnt == 0) begin
            got_word = cap;
            got_n = ncap;
            cap = '0;
            ncap = 0;
            frames++;
        end
        if (tx_serial_oe_n === 1'b0) begin
            cap = {cap[14:0], tx_serial_out};
            ncap++;
        end
    end
endmodule : pcmsp_host_model

// [tb/pcmsp_top_tb.sv]
// self-checking bench of the pcm serial voice port
module pcmsp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcmsp_pkg::*;
    localparam logic [12:0] TXV = 13'h1a5c;
    localparam logic [12:0] RXD = 13'h0b37;
    logic sys_clk, nrst, tbc, rbc, tfs, rfs, rsi, mck, power_up_input;
    logic [12:0] tx_sample_data, rx_sample_data;
    logic tx_sample_valid, tx_sample_ready, tx_serial_out, tx_serial_oe_n, rx_sample_valid;
    logic [2:0] rx_atten_code;
    logic [4:0] rx_atten_db;
    logic long_frame_mode, standby, powered_down, tick_256k, tick_8k;
    logic [10:0] mclk_per_frame;
    pcmsp_mode_e port_mode;
    logic long_sel, fs_en;
    logic [1:0] rx_mode;
    logic [15:0] rx_word, got_word;
    int frames, got_n, cyc, err_count, cmp_count, n256, n8, nval;
    pcmsp_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .tx_bit_clock(tbc),
        .rx_bit_clock_or_mode_select(rbc), .tx_frame_sync(tfs), .rx_frame_sync(rfs),
        .rx_serial_in(rsi), .master_clock(mck), .power_up_input(power_up_input),
        .tx_sample_data(tx_sample_data), .tx_sample_valid(tx_sample_valid),
        .tx_sample_ready(tx_sample_ready), .tx_serial_out(tx_serial_out),
        .tx_serial_oe_n(tx_serial_oe_n), .rx_sample_data(rx_sample_data),
        .rx_sample_valid(rx_sample_valid), .rx_atten_code(rx_atten_code),
        .rx_atten_db(rx_atten_db), .long_frame_mode(long_frame_mode), .port_mode(port_mode),
        .standby(standby), .powered_down(powered_down), .mclk_per_frame(mclk_per_frame),
        .tick_256k(tick_256k), .tick_8k(tick_8k));
    pcmsp_host_model u_host (.long_sel(long_sel), .fs_en(fs_en), .rx_mode(rx_mode),
        .rx_word(rx_word), .tx_serial_out(tx_serial_out), .tx_serial_oe_n(tx_serial_oe_n),
        .tx_bit_clock(tbc), .rx_bit_clock_or_mode_select(rbc), .tx_frame_sync(tfs),
        .rx_frame_sync(rfs), .rx_serial_in(rsi), .master_clock(mck), .frames(frames),
        .got_word(got_word), .got_n(got_n));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_flag(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask : chk_flag
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    always @(posedge sys_clk) begin
        cyc++;
        n256 += int'(tick_256k === 1'b1);
        n8 += int'(tick_8k === 1'b1);
        nval += int'(rx_sample_valid === 1'b1);
        if (cyc >= 95000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic wait_frames(input int n);
        int target;
        target = frames + n;
        wait (frames >= target);
        @(posedge sys_clk);
        #1;
    endtask : wait_frames
    // sleeping port: fill the fifo until it refuses
    task automatic fill_asleep;
        tx_sample_data <= TXV;
        tx_sample_valid <= 1'b1;
        repeat (17) @(posedge sys_clk);
        tx_sample_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_flag(tx_sample_ready, 1'b0);
        chk_flag(powered_down, 1'b1);
        chk_flag(tx_serial_oe_n, 1'b1);
    endtask : fill_asleep
    // wake: two silent frames, then a short-sync word each way
    task automatic wake_short;
        int a256, a8, aval;
        @(posedge sys_clk);
        power_up_input <= 1'b1;
        wait_frames(3);
        chk_val(got_word, 16'h0000);
        chk_val(got_n, 16'h0000);
        a256 = n256;
        a8 = n8;
        aval = nval;
        wait_frames(1);
        chk_val(16'(n256 - a256), 16'd32);
        chk_val(16'(n8 - a8), 16'h0001);
        chk_val(16'(nval - aval), 16'h0001);
        chk_val(got_n, 16'd13);
        chk_val(got_word, {3'b000, TXV});
        chk_val(rx_sample_data, {3'b000, RXD});
        chk_flag(long_frame_mode, 1'b0);
        chk_val(mclk_per_frame, 16'd32);
    endtask : wake_short
    task automatic run_mode(input logic [1:0] m, input logic lng, input logic [15:0] rxw,
        input logic [15:0] txe);
        long_sel <= lng;
        rx_mode <= m;
        rx_word <= rxw;
        wait_frames(3);
        chk_flag(long_frame_mode, lng);
        chk_val(port_mode, m);
        chk_val(got_word, txe);
        chk_val(got_n, (m == 2'd1) ? 16'd16 : 16'd13);
        chk_val(rx_sample_data, {3'b000, RXD});
        chk_val(rx_atten_code, (m == 2'd2) ? 16'd5 : 16'd0);
        chk_val(rx_atten_db, (m == 2'd2) ? 16'd15 : 16'd0);
    endtask : run_mode
    task automatic drain_and_sleep;
        for (int i = 0; i < 8 && got_word !== 16'h0000; i++) wait_frames(1);
        chk_val(got_word, 16'h0000);
        chk_flag(tx_sample_ready, 1'b1);
        fs_en <= 1'b0;
        wait_frames(2);
        chk_flag(standby, 1'b1);
    endtask : drain_and_sleep
    initial begin
        nrst = 1'b0;
        power_up_input = 1'b0;
        tx_sample_valid = 1'b0;
        tx_sample_data = '0;
        long_sel = 1'b0;
        fs_en = 1'b1;
        rx_mode = 2'd0;
        rx_word = {3'b000, RXD};
        cyc = 0;
        err_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge sys_clk);
        #1;
        chk_flag(tx_serial_oe_n, 1'b1);
        chk_val(rx_atten_code, 16'h0000);
        chk_flag(tx_sample_ready, 1'b1);
        @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        fill_asleep();
        wake_short();
        run_mode(2'd0, 1'b1, {3'b000, RXD}, {3'b000, TXV});
        run_mode(2'd1, 1'b0, {{3{RXD[12]}}, RXD}, {{3{TXV[12]}}, TXV});
        run_mode(2'd2, 1'b0, {RXD, 3'd5}, {3'b000, TXV});
        drain_and_sleep();
        end_of_test();
    end
endmodule : pcmsp_top_tb
